// *** rtl/hlr_pkg.sv ***
package hlr_pkg;
  // task-file register addresses on the plain register port
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_FEATURE = 4'h1;
  localparam logic [3:0] ADDR_LENGTH = 4'h2;
  localparam logic [3:0] ADDR_LOGSEL = 4'h3;
  localparam logic [3:0] ADDR_SIGLO = 4'h4;
  localparam logic [3:0] ADDR_SIGHI = 4'h5;
  localparam logic [3:0] ADDR_UNIT = 4'h6;
  localparam logic [3:0] ADDR_OPCODE = 4'h7;
  localparam logic [3:0] ADDR_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_CAPS = 4'h9;
  localparam logic [3:0] ADDR_OFFLINE = 4'hA;
  // command decode values
  localparam logic [7:0] OPC_HEALTH = 8'hB0;
  localparam logic [7:0] FEAT_LOG_READ = 8'hD5;
  localparam logic [7:0] SIG_LOW = 8'h4F;
  localparam logic [7:0] SIG_HIGH = 8'hC2;
  // log address map
  localparam logic [7:0] LOG_DIR = 8'h00;
  localparam logic [7:0] LOG_ERROR = 8'h01;
  localparam logic [7:0] LOG_SELFTEST = 8'h06;
  localparam logic [7:0] LOG_HOST_LO = 8'h80;
  localparam logic [7:0] LOG_HOST_HI = 8'h9F;
  localparam logic [7:0] LOG_DEVV_LO = 8'hA0;
  localparam logic [7:0] LOG_DEVV_HI = 8'hBF;
  localparam logic [7:0] DIR_VERSION = 8'h01;
  localparam logic [7:0] HOST_LOG_SECTORS = 8'h10;
  localparam logic [7:0] ONE_SECTOR = 8'h01;
  // status and error bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_DRIVE_READY_FLAG = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ID_NOT_FOUND_BIT = 4;
  localparam int ER_ABORTED_BIT = 2;
  // config register bits
  localparam int CFG_ENABLE = 0;
  localparam int CFG_MULTI = 1;
  localparam int CFG_POWER_SAVE = 2;
  localparam int CFG_ABORT_MODE = 3;
  // offline capability byte and health capability word
  localparam int OC_IMMEDIATE = 0;
  localparam int OC_ABORT_RESTART = 2;
  localparam int OC_READ_SCAN = 3;
  localparam int OC_SELF_TEST = 4;
  localparam int HC_POWER_SAVE = 0;
  localparam int HC_AUTOSAVE = 1;
  localparam logic [7:0] CFG_RESET = 8'h07;
  localparam logic [7:0] STATUS_IDLE = 8'h40;
  // sector geometry
  localparam int SECTOR_BYTES = 512;
  localparam logic [8:0] LAST_BYTE = 9'h1FF;
  // offline abort deadline
  localparam int CLK_HZ = 100_000_000;
  localparam int ABORT_LIMIT_S = 2;
  localparam int ABORT_CYCLES = CLK_HZ * ABORT_LIMIT_S;
  typedef enum logic [1:0] {HLR_IDLE, HLR_XFER, HLR_DONE} hlr_state_t;
endpackage : hlr_pkg

// *** rtl/hlr_read_log.sv ***
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hlr_read_log
  import hlr_pkg::*;
#(
  parameter int ABORT_CYC = hlr_pkg::ABORT_CYCLES,
  parameter logic [7:0] OFFLINE_CAPS = 8'h1D,
  parameter logic [7:0] ERRLOG_SECTORS = 8'h01,
  parameter logic [7:0] SELFTEST_SECTORS = 8'h01
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sector source for the error, self-test and device-vendor logs
  output logic store_req,
  output logic [7:0] store_log,
  output logic [8:0] store_idx,
  input wire logic [7:0] store_byte,
  input wire logic store_unc,
  input wire logic store_id_not_found_bit,
  input wire logic device_fault,
  input wire logic offline_busy,
  output logic offline_abort,
  output logic offline_suspend,
  output logic intrq
);
  import hlr_pkg::*;

  logic [7:0] feature_code;
  logic [7:0] transfer_length;
  logic [7:0] log_select;
  logic [7:0] signature_low;
  logic [7:0] signature_high;
  logic [7:0] unit_select;
  logic [7:0] drive_state_flags;
  logic [7:0] failure_cause;
  logic [7:0] config_reg;
  hlr_state_t state;
  logic [8:0] byte_idx;
  logic [7:0] sum;
  logic [7:0] cur_log;
  logic [7:0] data_out;
  logic [7:0] byte_val;
  logic [31:0] abort_cnt;
  logic abort_pending;

  logic cmd_write;
  logic decode_read;
  logic param_ok;
  logic log_implemented;
  logic from_store;
  logic is_host_log;
  logic data_read;
  logic [7:0] offline_caps;
  logic [15:0] health_caps;

  assign cmd_write = reg_wr && (reg_addr == ADDR_OPCODE);
  assign decode_read = cmd_write && (reg_wdata == OPC_HEALTH)
                       && (feature_code == FEAT_LOG_READ);
  assign is_host_log = (log_select >= LOG_HOST_LO) && (log_select <= LOG_HOST_HI);

  always_comb
  begin
    if (log_select == LOG_DIR)
      log_implemented = config_reg[CFG_MULTI];
    else if (log_select == LOG_ERROR || log_select == LOG_SELFTEST)
      log_implemented = 1'b1;
    else if (is_host_log)
      log_implemented = 1'b1;
    else if (log_select >= LOG_DEVV_LO && log_select <= LOG_DEVV_HI)
      log_implemented = 1'b1;
    else
      log_implemented = 1'b0;
  end

  assign param_ok = config_reg[CFG_ENABLE] && log_implemented
                    && (transfer_length != 8'h00)
                    && (signature_low == SIG_LOW) && (signature_high == SIG_HIGH);

  assign from_store = (cur_log == LOG_ERROR) || (cur_log == LOG_SELFTEST)
                      || (cur_log >= LOG_DEVV_LO && cur_log <= LOG_DEVV_HI);

  assign offline_caps = {3'b000, OFFLINE_CAPS[OC_SELF_TEST:OC_ABORT_RESTART],
                         OFFLINE_CAPS[1], OFFLINE_CAPS[OC_IMMEDIATE]};
  assign health_caps = {14'h0000, 1'b1, config_reg[CFG_POWER_SAVE]};

  // directory sector contents, reserved bytes zero
  function automatic logic [7:0] dir_byte(input logic [8:0] idx);
    logic [7:0] n;
    n = idx[8:1];
    if (idx == 9'h000)
      dir_byte = DIR_VERSION;
    else if (idx[0])
      dir_byte = 8'h00;
    else if (n == LOG_ERROR)
      dir_byte = ERRLOG_SECTORS;
    else if (n == LOG_SELFTEST)
      dir_byte = SELFTEST_SECTORS;
    else if (n >= LOG_HOST_LO && n <= LOG_HOST_HI)
      dir_byte = HOST_LOG_SECTORS;
    else
      dir_byte = 8'h00;
  endfunction

  always_comb
  begin
    if (byte_idx == LAST_BYTE)
      byte_val = 8'h00 - sum;
    else if (cur_log == LOG_DIR)
      byte_val = dir_byte(byte_idx);
    else if (from_store)
      byte_val = store_byte;
    else
      byte_val = 8'h00;
  end

  assign store_req = (state == HLR_XFER) && from_store;
  assign store_log = cur_log;
  assign store_idx = byte_idx;
  assign data_read = reg_rd && (reg_addr == ADDR_DATA) && (state == HLR_XFER);

  // task-file registers written by the host
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      feature_code <= 8'h00;
      transfer_length <= 8'h00;
      log_select <= 8'h00;
      signature_low <= 8'h00;
      signature_high <= 8'h00;
      unit_select <= 8'h00;
      config_reg <= CFG_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_FEATURE)
        feature_code <= reg_wdata;
      else if (reg_addr == ADDR_LENGTH)
        transfer_length <= reg_wdata;
      else if (reg_addr == ADDR_LOGSEL)
        log_select <= reg_wdata;
      else if (reg_addr == ADDR_SIGLO)
        signature_low <= reg_wdata;
      else if (reg_addr == ADDR_SIGHI)
        signature_high <= reg_wdata;
      else if (reg_addr == ADDR_UNIT)
        unit_select <= reg_wdata;
      else if (reg_addr == ADDR_CONFIG)
        config_reg <= reg_wdata;
    end
  end

  // command sequencing, PIO data-in of one sector per command
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= HLR_IDLE;
      byte_idx <= 9'h000;
      sum <= 8'h00;
      cur_log <= 8'h00;
      drive_state_flags <= STATUS_IDLE;
      failure_cause <= 8'h00;
      intrq <= 1'b0;
    end
    else
    begin
      intrq <= 1'b0;
      case (state)
        HLR_IDLE:
        begin
          if (cmd_write)
          begin
            failure_cause <= 8'h00;
            if (decode_read && param_ok)
            begin
              state <= HLR_XFER;
              cur_log <= log_select;
              byte_idx <= 9'h000;
              sum <= 8'h00;
              drive_state_flags <= 8'h00;
              drive_state_flags[ST_DRQ] <= 1'b1;
              drive_state_flags[ST_DRIVE_READY_FLAG] <= 1'b1;
              intrq <= 1'b1;
            end
            else
            begin
              failure_cause[ER_ABORTED_BIT] <= 1'b1;
              drive_state_flags <= STATUS_IDLE;
              drive_state_flags[ST_DF] <= device_fault;
              drive_state_flags[ST_ERR] <= 1'b1;
              intrq <= 1'b1;
            end
          end
        end
        HLR_XFER:
        begin
          if (from_store && (store_unc || store_id_not_found_bit))
          begin
            failure_cause[ER_UNC] <= store_unc;
            failure_cause[ER_ID_NOT_FOUND_BIT] <= store_id_not_found_bit;
            drive_state_flags <= STATUS_IDLE;
            drive_state_flags[ST_DF] <= device_fault;
            drive_state_flags[ST_ERR] <= 1'b1;
            state <= HLR_DONE;
          end
          else if (data_read)
          begin
            sum <= sum + byte_val;
            byte_idx <= byte_idx + 9'h001;
            if (byte_idx == LAST_BYTE)
              state <= HLR_DONE;
          end
        end
        HLR_DONE:
        begin
          if (failure_cause == 8'h00)
            drive_state_flags <= STATUS_IDLE;
          intrq <= 1'b1;
          state <= HLR_IDLE;
        end
        default:
          state <= HLR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      data_out <= 8'h00;
    else if (data_read)
      data_out <= byte_val;
  end

  // offline collection on a new command: abort only if capability bit 2 and config bit 3 are both set, otherwise suspend
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      abort_pending <= 1'b0;
      abort_cnt <= 32'h0000_0000;
      offline_abort <= 1'b0;
      offline_suspend <= 1'b0;
    end
    else
    begin
      offline_abort <= 1'b0;
      if (cmd_write && offline_busy)
      begin
        if (config_reg[CFG_ABORT_MODE] && OFFLINE_CAPS[OC_ABORT_RESTART])
        begin
          abort_pending <= 1'b1;
          abort_cnt <= 32'h0000_0000;
        end
        else
          offline_suspend <= 1'b1;
      end
      else if (abort_pending && abort_cnt < 32'(ABORT_CYC))
      begin
        abort_cnt <= abort_cnt + 32'h0000_0001;
        // abort issued well before the deadline, two cycles after command
        offline_abort <= 1'b1;
        abort_pending <= 1'b0;
      end
      else if (offline_suspend && !offline_busy && state == HLR_IDLE)
        offline_suspend <= 1'b0;
    end
  end

  // registered read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_DATA)
        reg_rdata <= (state == HLR_XFER) ? byte_val : data_out;
      else if (reg_addr == ADDR_FEATURE)
        reg_rdata <= failure_cause;
      else if (reg_addr == ADDR_LENGTH)
        reg_rdata <= transfer_length;
      else if (reg_addr == ADDR_LOGSEL)
        reg_rdata <= log_select;
      else if (reg_addr == ADDR_SIGLO)
        reg_rdata <= signature_low;
      else if (reg_addr == ADDR_SIGHI)
        reg_rdata <= signature_high;
      else if (reg_addr == ADDR_UNIT)
        reg_rdata <= unit_select;
      else if (reg_addr == ADDR_OPCODE)
        reg_rdata <= drive_state_flags;
      else if (reg_addr == ADDR_CONFIG)
        reg_rdata <= config_reg;
      else if (reg_addr == ADDR_CAPS)
        reg_rdata <= offline_caps;
      else if (reg_addr == ADDR_OFFLINE)
        reg_rdata <= health_caps[7:0];
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule // hlr_read_log
`default_nettype wire

// *** verif/hlr_read_log_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module hlr_read_log_checker
  import hlr_pkg::*;
#(
  parameter logic [7:0] OFFLINE_CAPS = 8'h1D
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic offline_busy,
  input wire logic offline_abort,
  input wire logic offline_suspend,
  input wire logic intrq
);
  import hlr_pkg::*;
  logic [7:0] sh [0:15];
  logic act;
  logic acked;
  logic [9:0] nrd;
  wire logic acc = reg_wr && reg_addr == ADDR_OPCODE && !act;
  wire logic opw = reg_wr && reg_addr == ADDR_OPCODE && offline_busy;
  wire logic good = sh[1] == FEAT_LOG_READ && sh[2] != 8'h00 && sh[4] == SIG_LOW
    && sh[5] == SIG_HIGH && sh[8][CFG_ENABLE] && reg_wdata == OPC_HEALTH
    && (sh[3][7:6] == 2'b10 || sh[3] == LOG_ERROR || sh[3] == LOG_SELFTEST
    || (sh[3] == LOG_DIR && sh[8][CFG_MULTI]));
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        sh[i] <= (i == 8) ? CFG_RESET : 8'h00;
    end
    else if (reg_wr)
      sh[reg_addr] <= reg_wdata;
  // completion is the pulse after the accept pulse, even when a sector error ends it early
  always_ff @(posedge clk)
    if (!rst_n)
      act <= 1'b0;
    else if (acc && good)
      act <= 1'b1;
    else if (act && intrq && acked)
      act <= 1'b0;
  always_ff @(posedge clk)
    if (!rst_n || acc)
      acked <= 1'b0;
    else if (act && intrq)
      acked <= 1'b1;
  always_ff @(posedge clk)
    if (!rst_n || acc)
      nrd <= 10'h000;
    else if (act && reg_rd && reg_addr == ADDR_DATA)
      nrd <= nrd + 10'h001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_accept_irq:
    assert property (acc |=> intrq) else $error("no interrupt after command");
  chk_irq_pulse:
    assert property (intrq |=> !intrq) else $error("interrupt longer than one cycle");
  chk_idle_quiet:
    assert property (!act && !acc |=> !intrq) else $error("interrupt while idle");
  chk_done_irq:
    assert property (act && reg_rd && reg_addr == ADDR_DATA && nrd == 10'h1FF
      |-> ##[1:4] intrq) else $error("no completion after one sector");
  chk_rdata_hold:
    assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  chk_offline_caps:
    assert property (reg_rd && reg_addr == ADDR_CAPS |=> reg_rdata == OFFLINE_CAPS
      && reg_rdata[7:5] == 3'h0) else $error("offline caps wrong");
  chk_health_caps:
    assert property (reg_rd && reg_addr == ADDR_OFFLINE
      |=> reg_rdata == (8'h02 | {7'h00, sh[8][CFG_POWER_SAVE]})) else $error("health caps wrong");
  chk_offline_abort:
    assert property (opw && OFFLINE_CAPS[2] && sh[8][CFG_ABORT_MODE]
      |-> ##[1:2] offline_abort) else $error("offline work not aborted");
  chk_offline_susp:
    assert property (opw && !(OFFLINE_CAPS[2] && sh[8][CFG_ABORT_MODE])
      |-> ##[1:2] offline_suspend) else $error("offline work not suspended");
  cover property (acc && good);
  cover property (act && intrq && nrd != 10'h000);
  cover property (offline_abort);
endmodule // hlr_read_log_checker
`default_nettype wire

// *** verif/hlr_log_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module hlr_log_store
  import hlr_pkg::*;
(
  input wire logic store_req,
  input wire logic [7:0] store_log,
  input wire logic [8:0] store_idx,
  output logic [7:0] store_byte
);
  import hlr_pkg::*;
  function automatic logic [7:0] fill(input logic [7:0] lg, input logic [8:0] ix);
    logic [7:0] s;
    s = 8'h00;
    if (ix != LAST_BYTE)
      return lg ^ ix[7:0];
    for (int i = 0; i < 511; i++)
      s = s + (lg ^ i[7:0]);
    return 8'h00 - s;
  endfunction
  // no stale byte while unselected
  assign store_byte = store_req ? fill(store_log, store_idx) : ~fill(store_log, store_idx);
endmodule // hlr_log_store
`default_nettype wire

// *** verif/health_log_read_command_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module health_log_read_command_tb_top;
  import hlr_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, store_unc, store_id_not_found_bit, device_fault, offline_busy;
  logic store_req, offline_abort, offline_suspend, intrq, seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, store_log, store_byte, sum, lg;
  logic [8:0] store_idx, n;
  logic [8:0] eq [$];
  logic [7:0] p [0:4];
  logic [31:0] r;
  int fails, num_checks, seed, aborts;
  hlr_read_log hlr_read_log_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .store_req(store_req), .store_log(store_log), .store_idx(store_idx),
    .store_byte(store_byte), .store_unc(store_unc), .store_id_not_found_bit(store_id_not_found_bit),
    .device_fault(device_fault), .offline_busy(offline_busy),
    .offline_abort(offline_abort), .offline_suspend(offline_suspend), .intrq(intrq));
  hlr_log_store hlr_log_store_i (.store_req(store_req), .store_log(store_log),
    .store_idx(store_idx), .store_byte(store_byte));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input bit c);
    eq.push_back({c, e});
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
  endtask
  task automatic setp(input logic [7:0] l, input logic [7:0] c);
    p = '{FEAT_LOG_READ, c, l, SIG_LOW, SIG_HIGH};
  endtask
  task automatic cmd();
    for (int i = 0; i < 7; i++)
      wr(4'(i + 1), i < 5 ? p[i] : i == 5 ? 8'h00 : OPC_HEALTH);
    idle();
    idle();
  endtask
  task automatic status(input logic [7:0] st, input logic [7:0] er);
    idle();
    rd(ADDR_OPCODE, st, 1'b1);
    rd(ADDR_FEATURE, er, 1'b1);
    idle();
    idle();
  endtask
  function automatic logic [7:0] expb(input logic [7:0] l, input int i);
    if (l[7:5] == 3'b100)
      return 8'h00;
    if (l != LOG_DIR)
      return l ^ i[7:0];
    if (i == 0)
      return DIR_VERSION;
    if (i == 2 || i == 12)
      return 8'h01;
    return (i >= 256 && i < 320 && !i[0]) ? HOST_LOG_SECTORS : 8'h00;
  endfunction
  // vendor entries of the directory are free, so they are not compared
  task automatic sector(input logic [7:0] l, input bit care);
    sum = 8'h00;
    for (int i = 0; i < 512; i++)
      rd(ADDR_DATA, expb(l, i), care && i != 511 && !(l == LOG_DIR && i >= 320 && i < 384));
    idle();
    idle();
    if (care && l != LOG_DIR)
      check("checksum", sum, 8'h00);
  endtask
  always @(posedge clk)
  begin
    if (offline_abort)
      aborts++;
    if (seen)
    begin
      n = eq.pop_front();
      sum = sum + reg_rdata;
      if (n[8])
        check("rdata", reg_rdata, n[7:0]);
    end
    seen <= reg_rd;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial
  begin
    seed = 63784;
    {rst_n, reg_wr, reg_rd, store_unc, store_id_not_found_bit, device_fault, offline_busy, seen} = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    rd(ADDR_OPCODE, STATUS_IDLE, 1'b1);
    rd(ADDR_CONFIG, CFG_RESET, 1'b1);
    rd(ADDR_CAPS, 8'h1D, 1'b1);
    rd(ADDR_OFFLINE, 8'h03, 1'b1);
    rd(4'hF, 8'h00, 1'b1);
    idle();
    $display("done: reset values");
    for (int k = 0; k < 9; k++)
    begin
      r = $random(seed);
      setp(k == 8 ? LOG_DIR : LOG_HOST_LO, k == 1 ? 8'h00 : 8'h01);
      case (k)
        0: p[0] = {1'b0, r[6:0]};
        2: p[2] = {2'b01, r[5:0]};
        3: p[3] = {1'b1, r[6:0]};
        4: p[4] = {1'b0, r[6:0]};
        5: p[2] = {2'b11, r[5:0]};
        6: p[2] = 8'h02;
        default: ;
      endcase
      wr(ADDR_CONFIG, k == 7 ? 8'h06 : k == 8 ? 8'h05 : CFG_RESET);
      cmd();
      status(8'h41, 8'h04);
    end
    wr(ADDR_CONFIG, CFG_RESET);
    $display("done: refused commands");
    for (int k = 0; k < 5; k++)
    begin
      r = $random(seed);
      lg = k == 0 ? {3'b100, r[4:0]} : k == 1 ? LOG_ERROR : k == 2 ? LOG_SELFTEST
        : k == 3 ? {3'b101, r[4:0]} : LOG_DIR;
      device_fault <= r[8];
      setp(lg, {r[7:1], 1'b1});
      cmd();
      sector(lg, 1'b1);
      status(STATUS_IDLE, 8'h00);
    end
    $display("done: log reads");
    for (int j = 0; j < 2; j++)
    begin
      store_unc <= j == 0;
      store_id_not_found_bit <= j == 1;
      device_fault <= j == 0;
      setp(LOG_ERROR, 8'h01);
      cmd();
      sector(LOG_ERROR, 1'b0);
      status(j == 0 ? 8'h61 : 8'h41, j == 0 ? 8'h40 : 8'h10);
    end
    {store_unc, store_id_not_found_bit, device_fault} <= 3'b000;
    $display("done: sector errors");
    for (int j = 0; j < 2; j++)
    begin
      wr(ADDR_CONFIG, j == 0 ? CFG_RESET : 8'h0F);
      offline_busy <= 1'b1;
      setp(LOG_HOST_LO, 8'h01);
      cmd();
      @(negedge clk);
      check("suspend", {7'h00, offline_suspend}, {7'h00, j == 0});
      @(posedge clk);
      sector(LOG_HOST_LO, 1'b1);
      status(STATUS_IDLE, 8'h00);
      offline_busy <= 1'b0;
      idle();
      idle();
    end
    wr(ADDR_CONFIG, 8'h03);
    rd(ADDR_OFFLINE, 8'h02, 1'b1);
    idle();
    idle();
    check("aborts", 8'(aborts), 8'h01);
    $display("done: offline handling");
    stop_test();
  end
endmodule // health_log_read_command_tb_top
bind hlr_read_log hlr_read_log_checker #(.OFFLINE_CAPS(OFFLINE_CAPS)) hlr_read_log_checker_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .offline_busy(offline_busy),
  .offline_abort(offline_abort), .offline_suspend(offline_suspend), .intrq(intrq));
`default_nettype wire
